// ---- shared/sbt_pkg.sv ----
// Shared constants and carrier types for the simplex BCD character path
package sbt_pkg;

   // Character and buffer geometry
   localparam int SBT_CHAR_W     = 6;
   localparam int SBT_FIFO_DEPTH = 4;

   // Zone field codes, bit 1 is B and bit 0 is A
   localparam logic [1:0] SBT_ZONE_NONE = 2'h0;
   localparam logic [1:0] SBT_ZONE_A    = 2'h1;
   localparam logic [1:0] SBT_ZONE_B    = 2'h2;
   localparam logic [1:0] SBT_ZONE_AB   = 2'h3;

   // Core-storage codes that need special handling
   localparam logic [5:0] SBT_CORE_ZERO   = 6'h00;
   localparam logic [5:0] SBT_CORE_EIGHT2 = 6'h0a;
   localparam logic [5:0] SBT_CORE_ABZERO = 6'h30;

   // Simplex BCD codes those special cases become
   localparam logic [5:0] SBT_SBCD_ZERO   = 6'h0a;
   localparam logic [5:0] SBT_SBCD_EIGHT2 = 6'h10;
   localparam logic [5:0] SBT_SBCD_ABZERO = 6'h00;

   // Six-bit character: B A zone, then 8 4 2 1 digit
   typedef struct packed {
      logic [1:0] zone;
      logic [3:0] digit;
   } sbt_char_t;

   // Outgoing word from the assembly side, ctrl marks control data
   typedef struct packed {
      logic      ctrl;
      sbt_char_t ch;
   } sbt_wr_word_t;

   // Byte on the adapter buses with its parity bit
   typedef struct packed {
      logic      parity;
      sbt_char_t ch;
   } sbt_byte_t;

   // Reset values
   localparam sbt_byte_t SBT_BYTE_RST = 7'h00;
   localparam sbt_char_t SBT_CHAR_RST = 6'h00;

endpackage : sbt_pkg

// ---- hw/sbt_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module sbt_fifo #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   import sbt_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire  logic       push;
   wire  logic       pop;

   // Handshake decode
   assign in_ready  = (count != CNT_FULL);
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // Storage array, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule : sbt_fifo

`default_nettype wire

// ---- hw/sbt_char_path.sv ----
// Channel character path: simplex BCD translation and odd parity
`timescale 1ns/100ps
`default_nettype none

// Contract
// [R1] Every outgoing byte carries odd parity
// [R2] BCD mode translates write characters to simplex
// [R3] Binary mode writes characters unchanged
// [R4] Control data bypasses write translation
// [R5] Only B, A, 8, 2 bits change
// [R6] Translated character loads at ring pulse three
// [R7] Binary mode reads characters unchanged
// [R8] Sense data bypasses read translation
// [R9] Capture read byte on data-in and load
// [R10] Data accept at pulse three loads assembly
// [R11] Incoming parity is never checked
// [R12] Parity bit driven when data bits even
// [R13] Parity counts the untranslated character
// [R14] Zone swap translations invert the parity
// [R15] Eight-two to A translation blocks parity
// [R16] Zones AB to A, A to AB
// [R17] Zero-zone and AB-zero special codes mapped
// [R18] Read translation is the exact inverse
module sbt_char_path #(
   parameter int FIFO_DEPTH = sbt_pkg::SBT_FIFO_DEPTH
) (
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire logic                 bcd_mode,
   input  wire logic                 write_mode,
   input  wire logic                 char_ring_pulse_three,
   input  wire sbt_pkg::sbt_wr_word_t asm_wr,
   input  wire logic                 asm_wr_valid,
   output logic                      asm_wr_ready,
   output sbt_pkg::sbt_byte_t        wr_bus,
   output logic                      wr_strobe,
   output logic                      wr_starved,
   input  wire sbt_pkg::sbt_byte_t   rd_bus,
   input  wire logic                 data_in,
   input  wire logic                 read_load,
   input  wire logic                 sense_xfer,
   input  wire logic                 data_accept,
   output sbt_pkg::sbt_char_t        asm_rd,
   output logic                      asm_rd_valid
);
   import sbt_pkg::*;

   // Core storage to simplex BCD
   function automatic sbt_char_t to_simplex(input sbt_char_t c);
      sbt_char_t r;
      r = c;
      if (c == SBT_CORE_ZERO) begin
         r = SBT_SBCD_ZERO;                        // see [R17]
      end else if (c == SBT_CORE_EIGHT2) begin
         r = SBT_SBCD_EIGHT2;                      // see [R17]
      end else if (c == SBT_CORE_ABZERO) begin
         r = SBT_SBCD_ABZERO;                      // see [R17]
      end else if (c.zone == SBT_ZONE_AB) begin
         r.zone = SBT_ZONE_A;                      // see [R16]
      end else if (c.zone == SBT_ZONE_A) begin
         r.zone = SBT_ZONE_AB;                     // see [R16]
      end
      return r;
   endfunction : to_simplex

   // Simplex BCD back to core storage
   function automatic sbt_char_t to_core(input sbt_char_t c);
      sbt_char_t r;
      r = c;
      if (c == SBT_SBCD_ZERO) begin
         r = SBT_CORE_ZERO;                        // see [R18]
      end else if (c == SBT_SBCD_EIGHT2) begin
         r = SBT_CORE_EIGHT2;                      // see [R18]
      end else if (c == SBT_SBCD_ABZERO) begin
         r = SBT_CORE_ABZERO;                      // see [R18]
      end else if (c.zone == SBT_ZONE_AB) begin
         r.zone = SBT_ZONE_A;                      // see [R18]
      end else if (c.zone == SBT_ZONE_A) begin
         r.zone = SBT_ZONE_AB;                     // see [R18]
      end
      return r;
   endfunction : to_core

   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------

   localparam int WR_W = $bits(sbt_wr_word_t);

   logic [WR_W-1:0]    head_bits;
   wire  sbt_wr_word_t head;
   logic               head_valid;
   wire  logic         wr_load;
   wire  logic         wr_xlat;
   wire  sbt_char_t    wr_xchar;
   wire  sbt_char_t    wr_char;
   wire  logic         wr_raw_par;
   wire  logic         wr_par_fix;
   wire  logic         wr_par_block;
   wire  logic         wr_par;

   // Buffer between assembly register and character register
   sbt_fifo #(
      .WIDTH (WR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_data   (asm_wr),
      .in_valid  (asm_wr_valid),
      .in_ready  (asm_wr_ready),
      .out_data  (head_bits),
      .out_valid (head_valid),
      .out_ready (wr_load)
   );

   assign head = head_bits;

   // Translation runs on the head word as soon as it is present
   assign wr_xlat  = bcd_mode && !head.ctrl;       // see [R2] see [R4]
   assign wr_xchar = to_simplex(head.ch);
   // 4 and 1 bits wired straight from the head word
   assign wr_char.zone     = wr_xlat ? wr_xchar.zone : head.ch.zone;
   assign wr_char.digit[3] = wr_xlat ? wr_xchar.digit[3]
                                     : head.ch.digit[3]; // see [R5]
   assign wr_char.digit[2] = head.ch.digit[2];    // see [R5]
   assign wr_char.digit[1] = wr_xlat ? wr_xchar.digit[1]
                                     : head.ch.digit[1]; // see [R5]
   assign wr_char.digit[0] = head.ch.digit[0];    // see [R5] see [R3]

   // Parity from the untranslated character, high on even count
   assign wr_raw_par = ~(^head.ch.digit ^ ^head.ch.zone); // see [R12] see [R13]

   // Zone swap between A and AB changes the bit count by one
   assign wr_par_fix = wr_xlat &&
      (((head.ch.zone == SBT_ZONE_AB) && (wr_char.zone == SBT_ZONE_A)) ||
       ((head.ch.zone == SBT_ZONE_A) && (wr_char.zone == SBT_ZONE_AB)));
                                                   // see [R14]

   // Eight-two becoming a lone A loses a bit, suppress parity
   assign wr_par_block = wr_xlat && (head.ch == SBT_CORE_EIGHT2); // see [R15]

   assign wr_par = wr_par_block ? 1'b0 : (wr_raw_par ^ wr_par_fix); // see [R1]

   // Character register loads at pulse three of a write service
   assign wr_load = write_mode && char_ring_pulse_three && head_valid;
                                                   // see [R6]

   // Character register and write bus
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_bus <= SBT_BYTE_RST;
      end else if (wr_load) begin
         wr_bus <= '{parity: wr_par, ch: wr_char};  // see [R1] see [R6]
      end
   end

   // Load strobe and empty-buffer warning, one cycle each
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_strobe  <= 1'b0;
         wr_starved <= 1'b0;
      end else begin
         wr_strobe  <= wr_load;
         wr_starved <= write_mode && char_ring_pulse_three && !head_valid;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------

   sbt_byte_t rd_meta;
   sbt_byte_t rd_sync;
   logic      din_meta;
   logic      din_sync;
   sbt_char_t rd_creg;
   wire logic      rd_capture;
   wire logic      rd_xlat;
   wire sbt_char_t rd_xchar;
   wire sbt_char_t rd_char;
   wire logic      rd_accept;

   // Two-stage synchronisers on the adapter pins
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_meta  <= SBT_BYTE_RST;
         rd_sync  <= SBT_BYTE_RST;
         din_meta <= 1'b0;
         din_sync <= 1'b0;
      end else begin
         rd_meta  <= rd_bus;
         rd_sync  <= rd_meta;
         din_meta <= data_in;
         din_sync <= din_meta;
      end
   end

   // Both qualifiers needed to take the byte
   assign rd_capture = !write_mode && din_sync && read_load; // see [R9]

   // Character register on read, parity bit dropped unchecked
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_creg <= SBT_CHAR_RST;
      end else if (rd_capture) begin
         rd_creg <= rd_sync.ch;                    // see [R9] see [R11]
      end
   end

   // Read translation, bypassed for binary mode and sense data
   assign rd_xlat  = bcd_mode && !sense_xfer;     // see [R8]
   assign rd_xchar = to_core(rd_creg);
   assign rd_char.zone     = rd_xlat ? rd_xchar.zone : rd_creg.zone;
   assign rd_char.digit[3] = rd_xlat ? rd_xchar.digit[3]
                                     : rd_creg.digit[3]; // see [R5]
   assign rd_char.digit[2] = rd_creg.digit[2];    // see [R5]
   assign rd_char.digit[1] = rd_xlat ? rd_xchar.digit[1]
                                     : rd_creg.digit[1]; // see [R5]
   assign rd_char.digit[0] = rd_creg.digit[0];    // see [R5] see [R7]

   // Data accept at pulse three moves it to the assembly side
   assign rd_accept = !write_mode && char_ring_pulse_three && data_accept;
                                                   // see [R10]

   // Assembly register input and its valid pulse
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         asm_rd       <= SBT_CHAR_RST;
         asm_rd_valid <= 1'b0;
      end else begin
         asm_rd_valid <= rd_accept;
         if (rd_accept) begin
            asm_rd <= rd_char;                     // see [R10] see [R7]
         end
      end
   end

endmodule : sbt_char_path

`default_nettype wire

// ---- sim/sbt_char_path_checker.sv ----
// Port-level assertions for the character path
`timescale 1ns/100ps
`default_nettype none
module sbt_char_path_checker
   import sbt_pkg::*;
(
   input wire logic               clk_sys,
   input wire logic               sys_rst,
   input wire logic               write_mode,
   input wire logic               char_ring_pulse_three,
   input wire logic               data_accept,
   input wire sbt_pkg::sbt_byte_t wr_bus,
   input wire logic               wr_strobe,
   input wire logic               wr_starved,
   input wire sbt_pkg::sbt_char_t asm_rd,
   input wire logic               asm_rd_valid
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Pulse three on the write and read services
   sequence s_load;
      write_mode && char_ring_pulse_three;
   endsequence
   sequence s_accept;
      !write_mode && char_ring_pulse_three && data_accept;
   endsequence
   // Write side: one answer per pulse, odd bytes, held register
   a_load_answer: assert property (
      s_load |=> wr_strobe ^ wr_starved) else $error("pulse gave no answer");
   a_strobe_cause: assert property (
      wr_strobe |-> $past(write_mode) && $past(char_ring_pulse_three))
      else $error("strobe without pulse three");
   a_starve_cause: assert property (
      wr_starved |-> $past(write_mode) && $past(char_ring_pulse_three))
      else $error("starve without pulse three");
   a_wr_odd: assert property (
      wr_strobe |-> ^wr_bus) else $error("even byte on write bus");
   a_wr_hold: assert property (
      !wr_strobe |-> $stable(wr_bus)) else $error("write bus moved");
   // Read side: accept answers next cycle, result held
   a_accept_answer: assert property (
      s_accept |=> asm_rd_valid) else $error("accept not answered");
   a_rd_cause: assert property (
      asm_rd_valid |-> !$past(write_mode) && $past(data_accept)
         && $past(char_ring_pulse_three)) else $error("stray read valid");
   a_rd_hold: assert property (
      !asm_rd_valid |-> $stable(asm_rd)) else $error("read char moved");
endmodule : sbt_char_path_checker

bind sbt_char_path sbt_char_path_checker i_chk (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .write_mode(write_mode),
   .char_ring_pulse_three(char_ring_pulse_three),
   .data_accept(data_accept), .wr_bus(wr_bus), .wr_strobe(wr_strobe),
   .wr_starved(wr_starved), .asm_rd(asm_rd), .asm_rd_valid(asm_rd_valid));
`default_nettype wire

// ---- sim/sbt_adapter_model.sv ----
// Behavioural adapter driving the read bus pins
`timescale 1ns/100ps
`default_nettype none
module sbt_adapter_model
   import sbt_pkg::*;
(
   input  wire logic                clk_sys,
   output var sbt_pkg::sbt_byte_t   rd_bus,
   output var logic                 data_in
);
   // Pins idle until a byte is offered
   initial begin
      rd_bus  = SBT_BYTE_RST;
      data_in = 1'b0;
   end
   // Offer a byte, qualifier raised after lag cycles
   task automatic present(input sbt_char_t ch, input logic bad,
                          input int lag);
      rd_bus.ch     = ch;
      rd_bus.parity = ~^ch ^ bad;
      repeat (lag) @(negedge clk_sys);
      data_in = 1'b1;
   endtask : present
   // Released bus shows no stale value
   task automatic withdraw();
      rd_bus  = ~rd_bus;
      data_in = 1'b0;
   endtask : withdraw
endmodule : sbt_adapter_model
`default_nettype wire

// ---- sim/sbt_char_path_tb_top.sv ----
// Self-checking bench for the character path
`timescale 1ns/100ps
`default_nettype none
module sbt_char_path_tb_top;
   import sbt_pkg::*;
   localparam int FD = 4;
   logic         clk_sys, sys_rst, bcd_mode, write_mode, cr3;
   logic         asm_wr_valid, asm_wr_ready, wr_strobe, wr_starved;
   logic         data_in, read_load, sense_xfer, data_accept, asm_rd_valid;
   sbt_wr_word_t asm_wr;
   sbt_byte_t    wr_bus, rd_bus;
   sbt_char_t    asm_rd;
   int           bad_count, n_compared;

   sbt_char_path #(.FIFO_DEPTH(FD)) i_dut (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .bcd_mode(bcd_mode), .write_mode(write_mode),
      .char_ring_pulse_three(cr3), .asm_wr(asm_wr),
      .asm_wr_valid(asm_wr_valid), .asm_wr_ready(asm_wr_ready),
      .wr_bus(wr_bus), .wr_strobe(wr_strobe), .wr_starved(wr_starved),
      .rd_bus(rd_bus), .data_in(data_in), .read_load(read_load),
      .sense_xfer(sense_xfer), .data_accept(data_accept),
      .asm_rd(asm_rd), .asm_rd_valid(asm_rd_valid));
   sbt_adapter_model i_adapter (.clk_sys(clk_sys), .rd_bus(rd_bus),
      .data_in(data_in));

   // Compare and count
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Core to simplex mapping, and its inverse
   function automatic sbt_char_t to_sbcd(input sbt_char_t c);
      if (c == 6'h00) return 6'h0a;
      if (c == 6'h0a) return 6'h10;
      if (c == 6'h30) return 6'h00;
      if (c.zone[0]) c.zone[1] = ~c.zone[1];
      return c;
   endfunction : to_sbcd
   function automatic sbt_char_t to_core(input sbt_char_t s);
      if (s == 6'h0a) return 6'h00;
      if (s == 6'h10) return 6'h0a;
      if (s == 6'h00) return 6'h30;
      if (s.zone[0]) s.zone[1] = ~s.zone[1];
      return s;
   endfunction : to_core
   // Byte expected on the write bus
   function automatic sbt_byte_t exp_wr(input logic x, input sbt_char_t c);
      sbt_char_t t;
      t = x ? to_sbcd(c) : c;
      return {(x && c == 6'h0a) ? 1'b0 : ~^t, t};
   endfunction : exp_wr
   // Offer one word until the buffer takes it
   task automatic push(input logic ctrl, input sbt_char_t c);
      @(negedge clk_sys);
      asm_wr       = {ctrl, c};
      asm_wr_valid = 1'b1;
      while (!asm_wr_ready) @(negedge clk_sys);
      @(negedge clk_sys);
      asm_wr_valid = 1'b0;
   endtask : push
   // One ring pulse three, optionally with data accept
   task automatic pulse(input logic acc);
      @(negedge clk_sys);
      cr3         = 1'b1;
      data_accept = acc;
      @(negedge clk_sys);
      cr3         = 1'b0;
      data_accept = 1'b0;
   endtask : pulse
   // Every code in binary, BCD and control-data writes
   task automatic t_write_all();
      for (int m = 0; m < 3; m++) begin
         bcd_mode = m != 0;
         for (int i = 0; i < 64; i++) begin
            push(m == 2, 6'(i));
            pulse(1'b0);
            chk(wr_bus, exp_wr(m == 1, 6'(i)));
            chk(wr_bus, exp_wr(m == 1, 6'(i)));
            chk(7'(wr_strobe), 7'h1);
         end
      end
   endtask : t_write_all
   // Fill the buffer, refuse a fifth word, drain past empty
   task automatic t_fifo();
      for (int i = 0; i < FD; i++) push(1'b0, 6'(i + 5));
      chk(7'(asm_wr_ready), 7'h0);
      asm_wr       = 7'h3f;
      asm_wr_valid = 1'b1;
      repeat (2) @(negedge clk_sys);
      asm_wr_valid = 1'b0;
      for (int i = 0; i <= FD; i++) begin
         pulse(1'b0);
         if (i < FD) chk(wr_bus, exp_wr(1'b1, 6'(i + 5)));
         chk(7'(wr_starved), 7'(i == FD));
      end
   endtask : t_fifo
   // Every code read in binary, BCD and sense modes
   task automatic t_read_all();
      sbt_char_t c, e;
      write_mode = 1'b0;
      for (int m = 0; m < 3; m++) begin
         bcd_mode   = m != 0;
         sense_xfer = m == 2;
         for (int i = 0; i < 64; i++) begin
            c = 6'(i);
            e = (m == 1) ? to_core(c) : c;
            i_adapter.present(c, c[0], i % 2);
            repeat (3) @(negedge clk_sys);
            read_load = 1'b1;
            @(negedge clk_sys);
            read_load = 1'b0;
            i_adapter.withdraw();
            pulse(1'b1);
            chk(7'(asm_rd), 7'(e));
            chk(7'(asm_rd_valid), 7'h1);
         end
      end
   endtask : t_read_all
   // Verdict and end of run
   task automatic give_verdict();
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Reset, then the scenarios
   initial begin
      {sys_rst, write_mode} = 2'h3;
      {bcd_mode, cr3, asm_wr_valid, read_load} = 4'h0;
      {sense_xfer, data_accept} = 2'h0;
      asm_wr = 7'h00;
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_write_all();
      t_fifo();
      t_read_all();
      give_verdict();
   end
   // Watchdog
   initial begin
      #100us;
      bad_count++;
      give_verdict();
   end
endmodule : sbt_char_path_tb_top
`default_nettype wire
